// File: nvsc_link_if.sv
// Purpose: filtered serial pin levels and edges from front end to core
// Assumes: one clock domain
// Notes:   levels are registered in the front end; edge flags are decoded from them combinationally
`timescale 1ns/1ns
`default_nettype none
interface nvsc_link_if;
  logic sck;
  logic si;
  logic cs_n;
  logic hold_n;
  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  modport front (output sck, si, cs_n, hold_n, sck_rise, cs_rise, cs_fall);
  modport core  (input  sck, si, cs_n, hold_n, sck_rise, cs_rise, cs_fall);
endinterface // nvsc_link_if
`default_nettype wire

// File: nvsc_master_model.sv
// Purpose: serial master model for the special command pins
// Assumes: mode 0; sck period 16 clk_in cycles (160 ns)
// Notes:   sck stands low outside frames; si inverts when meaningless
`timescale 1ns/1ns
`default_nettype none
module nvsc_master_model
(
  // clock
  input  wire logic clk_in,
  // serial pins
  output var  logic sck_out,
  output var  logic si_out,
  output var  logic cs_n_out,
  output var  logic hold_n_out
);
  initial
  begin
    sck_out = 1'b0;
    si_out = 1'b0;
    cs_n_out = 1'b1;
    hold_n_out = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pause_now();
    logic keep;
    keep = si_out;
    hold_n_out <= 1'b0;
    wait_clk(8);
    // noise while paused must not count as bits
    repeat (3)
    begin
      sck_out <= 1'b1;
      si_out <= ~si_out;
      wait_clk(8);
      sck_out <= 1'b0;
      wait_clk(8);
    end
    si_out <= keep;
    wait_clk(8);
    hold_n_out <= 1'b1;
    wait_clk(8);
  endtask
  task automatic frame(input logic [7:0] op, input int nbits, input bit pause_at3);
    int i;
    cs_n_out <= 1'b0;
    wait_clk(8);
    for (i = 0; i < nbits; i++)
    begin
      si_out <= op[7 - (i % 8)];
      wait_clk(8);
      if (pause_at3 && i == 3)
        pause_now();
      sck_out <= 1'b1;
      wait_clk(8);
      sck_out <= 1'b0;
    end
    wait_clk(8);
    cs_n_out <= 1'b1;
    si_out <= ~si_out;
    wait_clk(16);
  endtask
endmodule // nvsc_master_model
`default_nettype wire

// File: nvsc_pin_sync.sv
// Purpose: three-stage synchronisers and edge finding for the serial pins
// Assumes: pins are asynchronous to clk_in
// Notes:   a level counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module nvsc_pin_sync
(
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  // raw pins
  input  wire logic [nvsc_pkg::PIN_N-1:0] pins_in,
  // filtered result
  nvsc_link_if.front                      link
);
  logic [nvsc_pkg::PIN_N-1:0] stage1;
  logic [nvsc_pkg::PIN_N-1:0] stage2;
  logic [nvsc_pkg::PIN_N-1:0] stage3;
  logic [nvsc_pkg::PIN_N-1:0] level;
  logic [nvsc_pkg::PIN_N-1:0] level_d;

  genvar i;
  generate
    for (i = 0; i < nvsc_pkg::PIN_N; i++)
    begin : g_pin
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          stage1[i]  <= nvsc_pkg::PIN_IDLE[i];
          stage2[i]  <= nvsc_pkg::PIN_IDLE[i];
          stage3[i]  <= nvsc_pkg::PIN_IDLE[i];
          level[i]   <= nvsc_pkg::PIN_IDLE[i];
          level_d[i] <= nvsc_pkg::PIN_IDLE[i];
        end
        else
        begin
          stage1[i] <= pins_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // stage1 feeds stage2 only; filter looks at 2 and 3
          if (stage2[i] == stage3[i])
            level[i] <= stage3[i];
          level_d[i] <= level[i];
        end
      end
    end
  endgenerate

  assign link.sck      = level[nvsc_pkg::PIN_SCK];
  assign link.si       = level[nvsc_pkg::PIN_SI];
  assign link.cs_n     = level[nvsc_pkg::PIN_CS_N];
  assign link.hold_n   = level[nvsc_pkg::PIN_HOLD_N];
  assign link.sck_rise = level[nvsc_pkg::PIN_SCK] & ~level_d[nvsc_pkg::PIN_SCK];
  assign link.cs_rise  = level[nvsc_pkg::PIN_CS_N] & ~level_d[nvsc_pkg::PIN_CS_N];
  assign link.cs_fall  = ~level[nvsc_pkg::PIN_CS_N] & level_d[nvsc_pkg::PIN_CS_N];
endmodule // nvsc_pin_sync
`default_nettype wire

// File: nvsc_pkg.sv
// Purpose: shared constants for the nonvolatile special command decoder
// Assumes: serial mode 0 or 3, data sampled on rising serial clock
// Notes:   busy times are top-level parameters
package nvsc_pkg;
  localparam logic [7:0] OP_SOFT_SAVE    = 8'h3c;
  localparam logic [7:0] OP_SOFT_RESTORE = 8'h60;
  localparam logic [7:0] OP_AUTOSAVE_ON  = 8'h59;
  localparam logic [7:0] OP_AUTOSAVE_OFF = 8'h19;
  // arbitrary default, overridable at the top
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam int         OPCODE_BITS     = 8;
  localparam int         CNT_W           = 4;
  localparam logic [CNT_W-1:0] CNT_FULL  = 4'h8;
  localparam logic [CNT_W-1:0] CNT_OVER  = 4'h9;
  localparam int         TMR_W           = 12;
  // pin vector positions and idle levels
  localparam int         PIN_SCK         = 0;
  localparam int         PIN_SI          = 1;
  localparam int         PIN_CS_N        = 2;
  localparam int         PIN_HOLD_N      = 3;
  localparam int         PIN_N           = 4;
  localparam logic [3:0] PIN_IDLE        = 4'hc;
  localparam logic       WEN_RESET       = 1'b0;
endpackage

// File: nvsc_top.sv
// Purpose: decodes nonvolatile special commands and the pause pin of a serial SRAM
// Assumes: serial clock well below clk_in / 6; mode 0 or 3
// Notes:   save / restore cycles are signalled by start pulses and a busy level
// Functional notes
// R1 - first byte save opcode with write latch set starts a full array save
// R2 - save runs whether or not the array was written since last cycle
// R3 - master sets the write latch before sending save
// R4 - any accepted special command clears the write latch at chip-select rise
// R5 - restore opcode with write latch set starts a full array restore
// R6 - master sets the write latch before sending restore
// R7 - autosave-on opcode with latch set sets the power-fail save flag
// R8 - autosave-off opcode with latch set clears the power-fail save flag
// R9 - power-fail save flag is volatile; only a later save records it
// R10 - variants with power-fail save reset with the flag set
// R11 - variant without it goes busy for sequence time, flag stays clear
// R12 - the opcode is the first byte after chip select falls
// R13 - master lowers pause pin only while serial clock is low
// R14 - master keeps chip select low throughout a pause
// R15 - pause keeps command, shift and bit position state intact
// R16 - pause ignores clock and data and leaves serial output undriven
// R17 - master releases pause pin while serial clock is low
// R18 - with write latch clear, special commands are ignored
// R19 - write-unlock command sets the latch; latch is clear after reset
// R20 - busy level shown while a cycle runs; no commands accepted meanwhile
// R21 - save, restore and sequence busy times are parameters
// R22 - command acts only at chip-select rise after exactly eight bits
`timescale 1ns/1ns
`default_nettype none
module nvsc_top
#(
  parameter bit                       HAS_AUTOSAVE  = 1'b1,
  parameter logic [7:0]               UNLOCK_OPCODE = nvsc_pkg::OP_WRITE_UNLOCK,
  parameter logic [nvsc_pkg::TMR_W-1:0] SAVE_CYCLES    = 12'h3e8,
  parameter logic [nvsc_pkg::TMR_W-1:0] RESTORE_CYCLES = 12'h064,
  parameter logic [nvsc_pkg::TMR_W-1:0] SEQ_CYCLES     = 12'h032
)
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // serial pins from the master
  input  wire logic sck_in,
  input  wire logic si_in,
  input  wire logic cs_n_in,
  input  wire logic hold_n_in,
  // serial output pin
  output var  logic so_out,
  output var  logic so_oe_out,
  // nonvolatile engine control
  output var  logic save_start_out,
  output var  logic restore_start_out,
  output var  logic busy_out,
  // state
  output var  logic write_enable_out,
  output var  logic power_fail_save_out,
  output var  logic paused_out
);
  nvsc_link_if link ();

  nvsc_pin_sync u_sync
  (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .pins_in ({hold_n_in, cs_n_in, si_in, sck_in}),
    .link    (link.front)
  );

  logic [7:0]                  shreg;
  logic [nvsc_pkg::CNT_W-1:0]  bit_cnt;
  logic [nvsc_pkg::TMR_W-1:0]  busy_cnt;
  logic                        frame_end;
  logic                        byte_ok;
  logic                        accept;
  logic                        is_special;
  logic                        take_save;
  logic                        take_restore;
  logic                        take_on;
  logic                        take_off;

  function automatic logic special_op(input logic [7:0] op);
    special_op = (op == nvsc_pkg::OP_SOFT_SAVE) || (op == nvsc_pkg::OP_SOFT_RESTORE) ||
                 (op == nvsc_pkg::OP_AUTOSAVE_ON) || (op == nvsc_pkg::OP_AUTOSAVE_OFF);
  endfunction

  // R22 exact byte, decoded only when the frame closes
  assign frame_end    = link.cs_rise;
  assign byte_ok      = frame_end && (bit_cnt == nvsc_pkg::CNT_FULL);
  assign is_special   = special_op(shreg);
  // R18 latch must be set; R20 nothing accepted while busy
  assign accept       = byte_ok && write_enable_out && !busy_out;
  // R1 R2 save is never skipped for an unwritten array
  assign take_save    = accept && (shreg == nvsc_pkg::OP_SOFT_SAVE);
  // R5
  assign take_restore = accept && (shreg == nvsc_pkg::OP_SOFT_RESTORE);
  assign take_on      = accept && (shreg == nvsc_pkg::OP_AUTOSAVE_ON);
  assign take_off     = accept && (shreg == nvsc_pkg::OP_AUTOSAVE_OFF);

  // R13 R14 R17 pause entered and left with clock low inside a frame; cleared at any clock level while chip select is high
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      paused_out <= 1'b0;
    else if (link.cs_n)
      paused_out <= 1'b0;
    else if (!link.sck)
      paused_out <= !link.hold_n;
  end

  // R12 R15 R16 bit capture from chip-select fall, frozen while paused
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shreg   <= 8'h00;
      bit_cnt <= '0;
    end
    else if (link.cs_fall)
    begin
      shreg   <= 8'h00;
      bit_cnt <= '0;
    end
    else if (!link.cs_n && !paused_out && link.sck_rise)
    begin
      if (bit_cnt < nvsc_pkg::CNT_FULL)
        shreg <= {shreg[6:0], link.si};
      // saturate so longer frames are told apart from a clean byte
      if (bit_cnt != nvsc_pkg::CNT_OVER)
        bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // R19 unlock sets the latch; R4 accepted special clears it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      write_enable_out <= nvsc_pkg::WEN_RESET;
    else if (byte_ok && !busy_out && shreg == UNLOCK_OPCODE)
      write_enable_out <= 1'b1;
    else if (accept && is_special)
      write_enable_out <= 1'b0;
  end

  // R9 plain flop, nothing stored; R10 reset value per variant
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      power_fail_save_out <= HAS_AUTOSAVE;
    // R11 variant without autosave keeps the flag clear
    else if (!HAS_AUTOSAVE)
      power_fail_save_out <= 1'b0;
    // R7
    else if (take_on)
      power_fail_save_out <= 1'b1;
    // R8
    else if (take_off)
      power_fail_save_out <= 1'b0;
  end

  // R21 R20 busy timer loaded per command
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy_cnt <= '0;
    else if (take_save)
      busy_cnt <= SAVE_CYCLES;
    else if (take_restore)
      busy_cnt <= RESTORE_CYCLES;
    // R11 both variants spend the sequence time
    else if (take_on || take_off)
      busy_cnt <= SEQ_CYCLES;
    else if (busy_cnt != '0)
      busy_cnt <= busy_cnt - 12'h001;
  end

  assign busy_out = (busy_cnt != '0);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      save_start_out    <= 1'b0;
      restore_start_out <= 1'b0;
    end
    else
    begin
      save_start_out    <= take_save;
      restore_start_out <= take_restore;
    end
  end

  // R16 no read path here, so output is never driven
  assign so_out    = 1'b0;
  assign so_oe_out = 1'b0;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_save_needs_latch: assert property (save_start_out |-> $past(write_enable_out)) // R1
    else $error("save started without write latch");
  chk_save_goes_busy: assert property (take_save |=> save_start_out && busy_out && busy_cnt == SAVE_CYCLES) // R2
    else $error("save did not start busy period");
  chk_latch_cleared: assert property ((accept && is_special) |=> !write_enable_out) // R4
    else $error("write latch not cleared after special command");
  chk_restore_start: assert property (take_restore |=> restore_start_out ##1 !restore_start_out) // R5
    else $error("restore start pulse wrong");
  chk_autosave_on: assert property (take_on |=> power_fail_save_out == HAS_AUTOSAVE) // R7
    else $error("autosave on not applied");
  chk_autosave_off: assert property (take_off |=> !power_fail_save_out) // R8
    else $error("autosave off not applied");
  chk_seq_busy: assert property ((take_on || take_off) |=> busy_cnt == SEQ_CYCLES) // R11
    else $error("sequence busy time not loaded");
  chk_pause_freeze: assert property ((paused_out && !link.cs_fall) |=> $stable(bit_cnt) && $stable(shreg)) // R15
    else $error("state moved while paused");
  chk_ignored_unlatched: assert property ((byte_ok && !write_enable_out) |=> // R18
    !save_start_out && !restore_start_out)
    else $error("command taken with latch clear");
  chk_bad_frame: assert property ((frame_end && bit_cnt != nvsc_pkg::CNT_FULL) |=> // R22
    !save_start_out && !restore_start_out)
    else $error("command taken from malformed frame");
  // a frame closing while busy must leave latch and starts untouched
  chk_busy_blocks: assert property ((byte_ok && busy_out) |=> // R20
    !write_enable_out && !save_start_out && !restore_start_out)
    else $error("command accepted while busy");
endmodule // nvsc_top
`default_nettype wire

// File: nvsc_top_tb.sv
// Purpose: self-checking bench for the special command decoder
// Assumes: busy times shortened by parameters
// Notes:   pulses and pause activity are counted by a monitor
`timescale 1ns/1ns
`default_nettype none
module nvsc_top_tb;
  // long enough that a whole frame fits inside one save
  localparam logic [11:0] SAVE_T = 12'h190;
  localparam logic [11:0] RST_T  = 12'h018;
  localparam logic [11:0] SEQ_T  = 12'h010;
  logic clk_in, rst_in, sck, si, cs_n, hold_n;
  logic so, so_oe, save_st, rest_st, busy, wen, pfs, paused, busy_q, pfs_q;
  int   errors, checked, n_save, n_rest, n_pause, n_oe, n_busy;
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  nvsc_master_model master (.clk_in(clk_in), .sck_out(sck), .si_out(si), .cs_n_out(cs_n), .hold_n_out(hold_n));
  nvsc_top #(.SAVE_CYCLES(SAVE_T), .RESTORE_CYCLES(RST_T), .SEQ_CYCLES(SEQ_T)) dut
  (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .si_in(si), .cs_n_in(cs_n), .hold_n_in(hold_n),
   .so_out(so), .so_oe_out(so_oe), .save_start_out(save_st), .restore_start_out(rest_st),
   .busy_out(busy), .write_enable_out(wen), .power_fail_save_out(pfs), .paused_out(paused));
  // variant without power-fail save, fed the same pins
  nvsc_top #(.HAS_AUTOSAVE(1'b0), .SAVE_CYCLES(SAVE_T), .RESTORE_CYCLES(RST_T), .SEQ_CYCLES(SEQ_T)) dut_q
  (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .si_in(si), .cs_n_in(cs_n), .hold_n_in(hold_n),
   .so_out(), .so_oe_out(), .save_start_out(), .restore_start_out(),
   .busy_out(busy_q), .write_enable_out(), .power_fail_save_out(pfs_q), .paused_out());
  always @(posedge clk_in)
  begin
    n_save <= n_save + (save_st === 1'b1);
    n_rest <= n_rest + (rest_st === 1'b1);
    n_pause <= n_pause + (paused === 1'b1);
    n_oe <= n_oe + (so_oe !== 1'b0);
    n_busy <= n_busy + (busy === 1'b1);
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp, input string what);
    chk_bit(got == exp, 1'b1, what);
  endtask
  // unlock, command, then wait out the busy span and measure it
  task automatic special(input logic [7:0] op, input logic [11:0] t);
    int k;
    int base;
    master.frame(nvsc_pkg::OP_WRITE_UNLOCK, 8, 1'b0);
    chk_bit(wen, 1'b1, "latch after unlock");
    // snapshot, not a reset: the monitor writes this counter too
    base = n_busy;
    master.frame(op, 8, 1'b0);
    chk_bit(wen, 1'b0, "latch after special");
    chk_bit(busy_q, 1'b1, "variant busy");
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      @(posedge clk_in);
    chk_bit(busy, 1'b0, "busy end");
    chk_bit(n_busy - base >= int'(t) && n_busy - base <= int'(t) + 1, 1'b1, "busy length");
  endtask
  task automatic t_reset();
    chk_bit(wen, 1'b0, "latch at reset");
    chk_bit(pfs, 1'b1, "flag at reset");
    chk_bit(busy, 1'b0, "busy at reset");
    chk_bit(pfs_q, 1'b0, "variant flag at reset");
    chk_bit(so_oe, 1'b0, "so released");
    chk_bit(so, 1'b0, "so idle level");
    $display("test reset done");
  endtask
  task automatic t_locked();
    master.frame(nvsc_pkg::OP_SOFT_SAVE, 8, 1'b0);
    chk_int(n_save, 0, "locked save");
    chk_bit(busy, 1'b0, "locked busy");
    $display("test locked done");
  endtask
  task automatic t_save();
    special(nvsc_pkg::OP_SOFT_SAVE, SAVE_T);
    chk_int(n_save, 1, "first save");
    special(nvsc_pkg::OP_SOFT_SAVE, SAVE_T);
    chk_int(n_save, 2, "repeat save");
    chk_int(n_rest, 0, "no restore");
    $display("test save done");
  endtask
  task automatic t_restore();
    special(nvsc_pkg::OP_SOFT_RESTORE, RST_T);
    chk_int(n_rest, 1, "restore pulse");
    chk_int(n_save, 2, "no save");
    $display("test restore done");
  endtask
  task automatic t_autosave();
    special(nvsc_pkg::OP_AUTOSAVE_OFF, SEQ_T);
    chk_bit(pfs, 1'b0, "flag off");
    special(nvsc_pkg::OP_AUTOSAVE_ON, SEQ_T);
    chk_bit(pfs, 1'b1, "flag on");
    chk_bit(pfs_q, 1'b0, "variant flag stays clear");
    chk_int(n_save, 2, "flag not saved");
    $display("test autosave done");
  endtask
  task automatic t_pause();
    int base;
    base = n_pause;
    master.frame(nvsc_pkg::OP_WRITE_UNLOCK, 8, 1'b1);
    chk_bit(n_pause - base > 40, 1'b1, "pause seen");
    chk_int(n_oe, 0, "so stays undriven");
    chk_bit(wen, 1'b1, "byte resumed");
    $display("test pause done");
  endtask
  task automatic t_short();
    master.frame(nvsc_pkg::OP_SOFT_SAVE, 7, 1'b0);
    master.frame(nvsc_pkg::OP_SOFT_SAVE, 9, 1'b0);
    chk_int(n_save, 2, "odd frames ignored");
    chk_bit(wen, 1'b1, "latch kept");
    $display("test short done");
  endtask
  // save on the kept latch, then an unlock sent while the save runs
  task automatic t_busy();
    int k;
    master.frame(nvsc_pkg::OP_SOFT_SAVE, 8, 1'b0);
    chk_int(n_save, 3, "save on kept latch");
    chk_bit(busy, 1'b1, "busy during save");
    master.frame(nvsc_pkg::OP_WRITE_UNLOCK, 8, 1'b0);
    chk_bit(wen, 1'b0, "unlock refused while busy");
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      @(posedge clk_in);
    chk_bit(busy, 1'b0, "busy end after refusal");
    $display("test busy done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    errors = 0;
    checked = 0;
    n_save = 0;
    n_rest = 0;
    n_pause = 0;
    n_oe = 0;
    n_busy = 0;
    rst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    t_reset();
    t_locked();
    t_save();
    t_restore();
    t_autosave();
    t_pause();
    t_short();
    t_busy();
    close_out();
  end
  initial
  begin
    #150000;
    errors++;
    close_out();
  end
endmodule // nvsc_top_tb
`default_nettype wire
